// File: logic/dlcr_regs.sv
// Channel configuration and loopback register bank for a dual line interface
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module dlcr_regs (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [dlcr_pkg::ADDR_W-1:0] host_addr,
    input  wire logic                  host_write,
    input  wire logic                  host_read,
    input  wire logic [dlcr_pkg::DATA_W-1:0] host_wdata,
    output logic [dlcr_pkg::DATA_W-1:0] host_rdata,
    input  wire logic [1:0]            tx_data,
    input  wire logic [1:0]            loop_data,
    input  wire logic [1:0]            rx_data,
    input  wire logic [1:0]            bipolar_violation,
    input  wire logic                  status_read,
    output logic                       rx_edge_select,
    output logic                       zero_run_detect_en,
    output logic [1:0]                 channel_power_down,
    output logic [1:0]                 jitter_place_sel0,
    output logic [1:0]                 jitter_place_sel1,
    output logic [1:0]                 tx_plain_bipolar_sel,
    output logic [1:0]                 rx_plain_bipolar_sel,
    output logic [1:0]                 factory_test,
    output logic [1:0]                 tx_all_ones,
    output logic [1:0]                 remote_loop,
    output logic [1:0]                 local_loop_a,
    output logic [1:0]                 local_loop_b,
    output logic [3:0]                 line_config_code_1,
    output logic [3:0]                 line_config_code_2,
    output logic [1:0]                 coder_mode,
    output logic [1:0]                 tx_line_data,
    output logic [1:0]                 rx_out_data,
    output logic [1:0]                 zero_run_active,
    output logic [1:0]                 bpv_latched
);
    import dlcr_pkg::*;

    logic [7:0] cfg_a_q [2];
    logic [7:0] cfg_b_q [2];
    logic [7:0] rdata_q;

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_a_q[0] <= CONFIG_A_RESET;
            cfg_a_q[1] <= CONFIG_A_RESET;
            cfg_b_q[0] <= CONFIG_B_RESET;
            cfg_b_q[1] <= CONFIG_B_RESET;
        end else if (host_write) begin
            case (host_addr)
                CH1_CONFIG_A_ADDR: cfg_a_q[0] <= host_wdata;
                CH2_CONFIG_A_ADDR: cfg_a_q[1] <= host_wdata;
                CH1_CONFIG_B_ADDR: cfg_b_q[0] <= host_wdata;
                CH2_CONFIG_B_ADDR: cfg_b_q[1] <= host_wdata;
                default: ;
            endcase
        end
    end

    // Read data registered; unmapped offsets answer zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= UNMAPPED_READ;
        end else if (host_read) begin
            case (host_addr)
                CH1_CONFIG_A_ADDR: rdata_q <= cfg_a_q[0];
                CH2_CONFIG_A_ADDR: rdata_q <= cfg_a_q[1];
                CH1_CONFIG_B_ADDR: rdata_q <= cfg_b_q[0];
                CH2_CONFIG_B_ADDR: rdata_q <= cfg_b_q[1];
                default:           rdata_q <= UNMAPPED_READ;
            endcase
        end
    end
    assign host_rdata = rdata_q;

    //////////////////////////////////////////////////////////////////////////
    // Shared bits live in one channel's register only
    assign rx_edge_select     = cfg_a_q[0][RX_EDGE_BIT];
    assign zero_run_detect_en = cfg_a_q[1][ZERO_RUN_BIT];

    // Codes forwarded raw; rate mismatch is the host's to avoid
    assign line_config_code_1 = cfg_b_q[0][LINE_CODE_MSB:LINE_CODE_LSB];
    assign line_config_code_2 = cfg_b_q[1][LINE_CODE_MSB:LINE_CODE_LSB];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            assign channel_power_down[ch]   = cfg_a_q[ch][POWER_DOWN_BIT];
            assign jitter_place_sel0[ch]    = cfg_a_q[ch][JITTER_SEL0_BIT];
            assign jitter_place_sel1[ch]    = cfg_a_q[ch][JITTER_SEL1_BIT];
            assign tx_plain_bipolar_sel[ch] = cfg_a_q[ch][TX_PLAIN_BIT];
            assign rx_plain_bipolar_sel[ch] = cfg_a_q[ch][RX_PLAIN_BIT];
            assign factory_test[ch]         = cfg_a_q[ch][FACTORY_TEST_BIT];
            assign tx_all_ones[ch]          = cfg_b_q[ch][TX_ALL_ONES_BIT];
            assign remote_loop[ch]          = cfg_b_q[ch][REMOTE_LOOP_BIT];
            assign local_loop_a[ch]         = cfg_b_q[ch][LOCAL_LOOP_A_BIT];
            assign local_loop_b[ch]         = cfg_b_q[ch][LOCAL_LOOP_B_BIT];

            dlcr_channel_ctrl u_chan (
                .clk               (clk),
                .reset             (reset),
                .cfg_a             (cfg_a_q[ch]),
                .cfg_b             (cfg_b_q[ch]),
                .zero_run_en       (cfg_a_q[1][ZERO_RUN_BIT]),
                .tx_data           (tx_data[ch]),
                .loop_data         (loop_data[ch]),
                .rx_data           (rx_data[ch]),
                .bipolar_violation (bipolar_violation[ch]),
                .status_read       (status_read),
                .coder_mode        (coder_mode[ch]),
                .tx_line_data      (tx_line_data[ch]),
                .rx_out_data       (rx_out_data[ch]),
                .zero_run_active   (zero_run_active[ch]),
                .bpv_latched_q     (bpv_latched[ch])
            );
        end
    endgenerate
endmodule : dlcr_regs

// File: logic/dlcr_pkg.sv
// Package: register map, field positions and reset values of the channel block
package dlcr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] CH1_CONFIG_A_ADDR = 8'h14;
    localparam logic [7:0] CH2_CONFIG_A_ADDR = 8'h15;
    localparam logic [7:0] CH1_CONFIG_B_ADDR = 8'h16;
    localparam logic [7:0] CH2_CONFIG_B_ADDR = 8'h17;
    localparam logic [7:0] CONFIG_A_RESET    = 8'h00;
    localparam logic [7:0] CONFIG_B_RESET    = 8'h0E;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;
    // Control A fields
    localparam int unsigned RX_EDGE_BIT      = 7;
    localparam int unsigned ZERO_RUN_BIT     = 7;
    localparam int unsigned POWER_DOWN_BIT   = 6;
    localparam int unsigned JITTER_SEL0_BIT  = 5;
    localparam int unsigned JITTER_SEL1_BIT  = 4;
    localparam int unsigned CODER_BIT        = 3;
    localparam int unsigned TX_PLAIN_BIT     = 2;
    localparam int unsigned RX_PLAIN_BIT     = 1;
    localparam int unsigned FACTORY_TEST_BIT = 0;
    // Control B fields
    localparam int unsigned TX_ALL_ONES_BIT  = 7;
    localparam int unsigned REMOTE_LOOP_BIT  = 6;
    localparam int unsigned LOCAL_LOOP_A_BIT = 5;
    localparam int unsigned LOCAL_LOOP_B_BIT = 4;
    localparam int unsigned LINE_CODE_MSB    = 3;
    localparam int unsigned LINE_CODE_LSB    = 0;
endpackage : dlcr_pkg

// File: logic/dlcr_channel_ctrl.sv
// One channel's datapath steering derived from its control fields
`timescale 1ns/1ps
module dlcr_channel_ctrl (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] cfg_a,
    input  wire logic [7:0] cfg_b,
    input  wire logic       zero_run_en,
    input  wire logic       tx_data,
    input  wire logic       loop_data,
    input  wire logic       rx_data,
    input  wire logic       bipolar_violation,
    input  wire logic       status_read,
    output logic            coder_mode,
    output logic            tx_line_data,
    output logic            rx_out_data,
    output logic            zero_run_active,
    output logic            bpv_latched_q
);
    import dlcr_pkg::*;

    logic local_a;
    logic local_b;
    logic any_loop;

    assign local_a  = cfg_b[LOCAL_LOOP_A_BIT];
    assign local_b  = cfg_b[LOCAL_LOOP_B_BIT];
    assign any_loop = local_a | local_b | cfg_b[REMOTE_LOOP_BIT];

    assign coder_mode      = cfg_a[CODER_BIT];
    assign zero_run_active = zero_run_en & cfg_a[CODER_BIT];

    // All ones beats any loopback source on the line
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_line_data <= 1'b0;
        end else if (cfg_b[TX_ALL_ONES_BIT]) begin
            tx_line_data <= 1'b1;
        end else if (any_loop) begin
            tx_line_data <= loop_data;
        end else begin
            tx_line_data <= tx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_out_data <= 1'b0;
        end else if (local_a & local_b) begin
            rx_out_data <= 1'b1;
        end else begin
            rx_out_data <= rx_data;
        end
    end

    // Violations count only with a line decoder in use; set beats clear
    always_ff @(posedge clk) begin
        if (reset) begin
            bpv_latched_q <= 1'b0;
        end else if (bipolar_violation & ~cfg_a[RX_PLAIN_BIT]) begin
            bpv_latched_q <= 1'b1;
        end else if (status_read) begin
            bpv_latched_q <= 1'b0;
        end
    end
endmodule : dlcr_channel_ctrl

// File: bench/dlcr_sva.sv
// Checker: timing relations on the register bank ports
`timescale 1ns/1ps
module dlcr_sva (
    input wire logic clk, reset, host_write, host_read, zero_run_detect_en,
    input wire logic [dlcr_pkg::ADDR_W-1:0] host_addr,
    input wire logic [dlcr_pkg::DATA_W-1:0] host_wdata, host_rdata,
    input wire logic [1:0] channel_power_down, coder_mode, tx_all_ones,
    input wire logic [1:0] tx_line_data, remote_loop, local_loop_a, loop_data,
    input wire logic [1:0] local_loop_b, rx_out_data, zero_run_active,
    input wire logic [1:0] bipolar_violation, rx_plain_bipolar_sel, bpv_latched
);
    import dlcr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_pd_write: assert property (host_write && host_addr == 8'h14 |=>
        channel_power_down[0] == $past(host_wdata[6])) else $error("pd");
    chk_coder_write: assert property (host_write && host_addr == 8'h15 |=>
        coder_mode[1] == $past(host_wdata[3])) else $error("coder");
    chk_unmapped_read: assert property (host_read && host_addr[7:2] != 6'h05
        |=> host_rdata == 8'h00) else $error("unmapped");
    chk_all_ones: assert property (tx_all_ones[0] |=> tx_line_data[0])
        else $error("all ones");
    chk_loop_path: assert property (!tx_all_ones[0] && (remote_loop[0] ||
        local_loop_a[0] || local_loop_b[0]) |=> tx_line_data[0] ==
        $past(loop_data[0])) else $error("loop path");
    chk_rx_ones: assert property (local_loop_a[0] && local_loop_b[0] |=>
        rx_out_data[0]) else $error("rx ones");
    chk_zero_run: assert property (zero_run_active[1] ==
        (zero_run_detect_en && coder_mode[1])) else $error("zero run");
    chk_bpv_set: assert property (bipolar_violation[0] &&
        !rx_plain_bipolar_sel[0] |=> bpv_latched[0]) else $error("bpv lost");
    chk_bpv_gate: assert property ($rose(bpv_latched[0]) |->
        $past(!rx_plain_bipolar_sel[0])) else $error("bpv spurious");
endmodule : dlcr_sva

// File: bench/dlcr_host.sv
// Host model: write and read cycles on the register port
`timescale 1ns/1ps
module dlcr_host (
    input  wire logic       clk,
    input  wire logic [7:0] host_rdata,
    output logic [7:0]      host_addr = 8'h00,
    output logic [7:0]      host_wdata = 8'h00,
    output logic            host_write = 1'b0,
    output logic            host_read = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        host_addr  <= a;
        // Factory test bit exists in configuration A only
        host_wdata <= (a[7:1] == 7'h0A) ? {d[7:1], 1'b0} : d;
        host_write <= 1'b1;
        @(posedge clk);
        host_write <= 1'b0;
        // Released lines show junk, never the old value
        host_addr  <= ~a;
        host_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        host_addr <= a;
        host_read <= 1'b1;
        @(posedge clk);
        host_read <= 1'b0;
        host_addr <= ~a;
        #1 d = host_rdata;
    endtask : rd
endmodule : dlcr_host

// File: bench/dlcr_regs_tb_top.sv
// Testbench: register access, field outputs and data steering
`timescale 1ns/1ps
module dlcr_regs_tb_top;
    import dlcr_pkg::*;
    typedef struct {logic [7:0] a, d, r;} dlcr_row_type;
    logic clk, reset, status_read, host_write, host_read;
    logic rx_edge_select, zero_run_detect_en;
    logic [7:0] host_addr, host_wdata, host_rdata, rd_v, a;
    logic [1:0] tx_data, loop_data, rx_data, bipolar_violation, factory_test;
    logic [1:0] channel_power_down, jitter_place_sel0, jitter_place_sel1;
    logic [1:0] tx_plain_bipolar_sel, rx_plain_bipolar_sel, bpv_latched;
    logic [1:0] tx_all_ones, remote_loop, local_loop_a, local_loop_b;
    logic [1:0] coder_mode, tx_line_data, rx_out_data, zero_run_active;
    logic [3:0] line_config_code_1, line_config_code_2;
    int fails = 0, num_checks = 0, cyc = 0;
    dlcr_row_type rows [5] = '{'{8'h14, 8'hFE, 8'hFE}, '{8'h15, 8'hA5, 8'hA4},
        '{8'h16, 8'hD9, 8'hD9}, '{8'h17, 8'h29, 8'h29}, '{8'h20, 8'hFF, 8'h00}};
    dlcr_host i_host (.clk, .host_rdata, .host_addr, .host_wdata, .host_write,
        .host_read);
    dlcr_regs i_dut (.clk, .reset, .host_addr, .host_write, .host_read,
        .host_wdata, .host_rdata, .tx_data, .loop_data, .rx_data,
        .bipolar_violation, .status_read, .rx_edge_select, .zero_run_detect_en,
        .channel_power_down, .jitter_place_sel0, .jitter_place_sel1,
        .tx_plain_bipolar_sel, .rx_plain_bipolar_sel, .factory_test,
        .tx_all_ones, .remote_loop, .local_loop_a, .local_loop_b,
        .line_config_code_1, .line_config_code_2, .coder_mode, .tx_line_data,
        .rx_out_data, .zero_run_active, .bpv_latched);
    function automatic logic [7:0] view(input logic [7:0] ad);
        int i;
        i = ad[0];
        if (ad[1]) return {tx_all_ones[i], remote_loop[i], local_loop_a[i],
            local_loop_b[i], i ? line_config_code_2 : line_config_code_1};
        return {i ? zero_run_detect_en : rx_edge_select, channel_power_down[i],
            jitter_place_sel0[i], jitter_place_sel1[i], coder_mode[i],
            tx_plain_bipolar_sel[i], rx_plain_bipolar_sel[i], factory_test[i]};
    endfunction : view
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic steer(input logic [7:0] b, input logic [7:0] lp);
        i_host.wr(8'h16, b);
        @(posedge clk);
        {tx_data, loop_data, rx_data} <= {2'b00, lp[1:0], 2'b00};
        repeat (2) @(posedge clk);
        #1 chk("tx line", 8'h01, 8'(tx_line_data[0]));
        chk("rx out", {7'h0, &b[5:4]}, 8'(rx_out_data[0]));
    endtask : steer
    task automatic bpv_try(input logic [7:0] cfg, input logic [7:0] e);
        i_host.wr(8'h14, cfg);
        @(posedge clk);
        bipolar_violation <= 2'b01;
        @(posedge clk);
        bipolar_violation <= 2'b00;
        @(posedge clk);
        #1 chk("bpv", e, 8'(bpv_latched[0]));
    endtask : bpv_try
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        {reset, status_read, tx_data, loop_data, rx_data} = 8'h80;
        bipolar_violation = 2'b00;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[k]) begin
            i_host.wr(rows[k].a, rows[k].d);
            if (rows[k].a[7:2] == 6'h05) chk("field", rows[k].r, view(rows[k].a));
            i_host.rd(rows[k].a, rd_v);
            chk("rdata", rows[k].r, rd_v);
        end
        // Loop paths carry loop data high over tx data low; the last case sends all ones over low loop data
        steer(8'h40, 8'h01);
        steer(8'h20, 8'h01);
        steer(8'h10, 8'h01);
        steer(8'hF0, 8'h00);
        bpv_try(8'h02, 8'h00);
        bpv_try(8'h00, 8'h01);
        // Status read and a new violation in one cycle: the set wins
        @(posedge clk);
        {status_read, bipolar_violation} <= 3'b101;
        @(posedge clk);
        bipolar_violation <= 2'b00;
        #1 chk("bpv set wins", 8'h01, {6'h0, bpv_latched});
        @(posedge clk);
        status_read <= 1'b0;
        #1 chk("bpv clear", 8'h00, {6'h0, bpv_latched});
        i_host.wr(8'h15, 8'h88);
        chk("zero run", 8'h02, {6'h0, zero_run_active});
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        for (a = 8'h14; a <= 8'h17; a++) begin
            i_host.rd(a, rd_v);
            chk("reset", a[1] ? CONFIG_B_RESET : CONFIG_A_RESET, rd_v);
        end
        final_report();
    end
endmodule : dlcr_regs_tb_top
bind dlcr_regs dlcr_sva i_sva (.clk, .reset, .host_write, .host_read,
    .zero_run_detect_en, .host_addr, .host_wdata, .host_rdata,
    .channel_power_down, .coder_mode, .tx_all_ones, .tx_line_data,
    .remote_loop, .local_loop_a, .loop_data, .local_loop_b, .rx_out_data,
    .zero_run_active, .bipolar_violation, .rx_plain_bipolar_sel, .bpv_latched);
